// File: hdl/iof_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IOF_MAP_SVH
`define IOF_MAP_SVH
`define IOF_CTRL 8'h00
`define IOF_PAT 8'h04
`define IOF_ROIX 8'h08
`define IOF_ROIY 8'h0c
`define IOF_MAXR 8'h10
`define IOF_RATIO 8'h14
`define IOF_RATE 8'h18
`define IOF_DROPS 8'h1c
`define IOF_STAT 8'h20
`define IOF_C_RUN 0
`define IOF_C_FMT 1
`define IOF_C_RX 4
`define IOF_C_RY 5
`define IOF_C_ISP 6
`define IOF_C_COMP 7
`define IOF_C_ADAPT 8
`define IOF_C_HOLD 9
`define IOF_C_PSEL 10
`define IOF_C_ADC 11
`define IOF_P_SENS 0
`define IOF_P_PIPE 8
`define IOF_ADC10 2'h0
`define IOF_ADC12 2'h1
`define IOF_ADC14 2'h2
`define IOF_ADC_RST 2'h1
`define IOF_MAXR_RST 32'hffffffff
`define IOF_RATIO_ONE 16'h0100
`define IOF_CHROMA_MID 8'h80
`define IOF_CLK_HZ 40000000
`define IOF_WIN_S 1
`define IOF_WIN_CYC (`IOF_WIN_S * `IOF_CLK_HZ)
`define IOF_DIV_STEPS 6'h20
`endif

// File: hdl/iof_pkg.sv
// Types of the image output formatter
package iof_pkg;
  typedef enum logic [2:0] {
    F_GREY8 = 3'b000,
    F_RG8 = 3'b001,
    F_WIDE = 3'b010,
    F_HALF = 3'b011,
    F_QUARTER = 3'b100,
    F_HALF_PK = 3'b101,
    F_QUARTER_PK = 3'b110,
    F_RSVD = 3'b111
  } iof_fmt_e;
  typedef enum logic [1:0] {
    PP_OFF = 2'b00,
    PP_INC = 2'b01,
    PP_VAR = 2'b10,
    PP_RSVD = 2'b11
  } iof_pp_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SOF = 2'b01,
    S_SCAN = 2'b10,
    S_DIV = 2'b11
  } iof_st_e;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic run;
    iof_fmt_e fmt;
    logic rx, ry, image_processing_core, comp, adapt, hold, psel;
    logic [1:0] adc;
    logic pat_s;
    iof_pp_e pat_p;
    logic [15:0] xo, xw, yo, yh;
    logic [31:0] maxr;
    iof_fmt_e c_fmt;
    logic c_rx, c_ry, c_comp, c_adapt, c_hold;
    iof_pp_e c_pat;
    logic [15:0] c_xo, c_xw, c_yo, c_yh;
    iof_st_e st;
    logic [15:0] x, y;
    logic drop;
    logic [1:0] ph;
    logic pend, m_sof, m_eol, m_eof, m_pon;
    logic [1:0] m_ph;
    logic [7:0] m_pat;
    logic ov, ocv, osof, oeol, oeof;
    logic [15:0] od;
    logic [7:0] inc, fidx, prev;
    logic [1:0] k;
    logic [31:0] wcnt, wbits, rate, raw, cbits, drops;
    logic [5:0] dcnt;
    logic [31:0] drem, dnum;
    logic [15:0] ratio;
  } iof_state_s;
endpackage

// File: hdl/iof_formatter.sv
// Image output formatter: pattern sources, mirroring, ROI, alignment, chroma, rate limit
`timescale 1ns/1ps
`default_nettype none
`include "iof_map.svh"
// Contract
// - Half-rate mode keeps all luma, one Cb and one Cr per two pixels.
// - Quarter-rate mode keeps all luma, each chroma once per four pixels.
// - Eight-bit luma and chroma keep the full 0 to 255 range.
// - Narrow formats drop the surplus low bits of each sample.
// - Wide formats left-align samples in 16 bits, zero-padding low bits.
// - Two selectable pattern sources: sensor side and pipeline entry.
// - Off disables the selected source; real data only when both off.
// - Increment pattern adds one per pixel, wrapping after 255.
// - Frame-sequence pattern varies per frame, restarts at acquisition start.
// - Pipeline pattern overrides sensor pattern when both are on.
// - Later processing treats pattern images like real data.
// - Exposure, gain and black level do not touch the pattern.
// - Compression only with core off and grey or red-green 8-bit format.
// - Adaptive mode updates coding tables; otherwise one fixed table.
// - Over the rate limit: drop frames if hold set, else slow down.
// - Read-only compression ratio, transmitted size over raw size.
// - Read-only measured output datarate in bytes per second.
// - Read-only count of frames dropped for the rate limit.
// - Horizontal mirror reverses pixels before ROI; Bayer phase may change.
// - Vertical mirror reverses lines before ROI; Bayer phase may change.
module iof_formatter
  import iof_pkg::*;
#(
  parameter int SENS_W = 1024,
  parameter int SENS_H = 768,
  parameter logic [31:0] WIN_CYC = `IOF_WIN_CYC,
  parameter logic [1:0] BAYER_BASE = 2'b00
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic fetch_req,
  output logic [15:0] fetch_x,
  output logic [15:0] fetch_y,
  input wire logic [13:0] pix_sample,
  input wire logic [7:0] pix_luma,
  input wire logic [7:0] pix_cb,
  input wire logic [7:0] pix_cr,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  output logic out_cvalid,
  output logic out_sof,
  output logic out_eol,
  output logic out_eof,
  output logic sensor_pattern_en,
  output logic [1:0] adc_depth_sel,
  output logic acq_running
);

  function automatic iof_state_s rst_val();
    iof_state_s r;
    r = '0;
    r.xw = 16'(SENS_W);
    r.yh = 16'(SENS_H);
    r.c_xw = 16'(SENS_W);
    r.c_yh = 16'(SENS_H);
    r.adc = `IOF_ADC_RST;
    r.maxr = `IOF_MAXR_RST;
    r.ratio = `IOF_RATIO_ONE;
    return r;
  endfunction

  localparam iof_state_s RST = rst_val();

  iof_state_s s;
  iof_state_s next_s;

  logic comp_ok;
  logic issue;
  logic [15:0] xl;
  logic [15:0] yl;

  always_comb begin
    // Compression is only legal on raw 8-bit single-channel data
    comp_ok = s.comp && !s.image_processing_core && (s.fmt == F_GREY8 || s.fmt == F_RG8);
    xl = 16'(s.c_xo + s.c_xw - 16'h0001);
    yl = 16'(s.c_yo + s.c_yh - 16'h0001);
    // One pixel in flight at a time keeps the output slot free on return
    issue = (s.st == S_SCAN) && !s.drop && !s.pend && (!s.ov || out_ready);
  end

  always_comb begin
    logic [31:0] cw;
    logic [31:0] m;
    logic [31:0] w;
    logic [15:0] a16;
    logic [7:0] b8;
    logic [7:0] lu;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [7:0] res;
    logic [7:0] mag;
    logic [3:0] bits;
    logic [31:0] rem;
    cw = '0;
    m = '0;
    w = '0;
    a16 = '0;
    b8 = '0;
    lu = '0;
    cb = '0;
    cr = '0;
    res = '0;
    mag = '0;
    bits = '0;
    rem = '0;
    next_s = s;

    // Wishbone slave, one wait state, unmapped reads return zero
    cw[`IOF_C_RUN] = s.run;
    cw[`IOF_C_FMT +: 3] = s.fmt;
    cw[`IOF_C_RX] = s.rx;
    cw[`IOF_C_RY] = s.ry;
    cw[`IOF_C_ISP] = s.image_processing_core;
    cw[`IOF_C_COMP] = s.comp;
    cw[`IOF_C_ADAPT] = s.adapt;
    cw[`IOF_C_HOLD] = s.hold;
    cw[`IOF_C_PSEL] = s.psel;
    cw[`IOF_C_ADC +: 2] = s.adc;
    m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (next_s.ack) begin
      unique case (wb_adr_i)
        `IOF_CTRL: next_s.rdat = cw;
        `IOF_PAT: next_s.rdat = {22'h0, s.pat_p, 7'h0, s.pat_s};
        `IOF_ROIX: next_s.rdat = {s.xw, s.xo};
        `IOF_ROIY: next_s.rdat = {s.yh, s.yo};
        `IOF_MAXR: next_s.rdat = s.maxr;
        `IOF_RATIO: next_s.rdat = {16'h0, s.ratio};
        `IOF_RATE: next_s.rdat = s.rate;
        `IOF_DROPS: next_s.rdat = s.drops;
        `IOF_STAT: next_s.rdat = {28'h0, s.st != S_IDLE,
          BAYER_BASE ^ {s.c_ry, s.c_rx}, comp_ok};
        default: next_s.rdat = '0;
      endcase
    end
    if (next_s.ack && wb_we_i) begin
      unique case (wb_adr_i)
        `IOF_CTRL: begin
          w = (cw & ~m) | (wb_dat_i & m);
          if (w[`IOF_C_RUN] && !s.run) begin
            next_s.fidx = '0;
            next_s.drops = '0;
          end
          next_s.run = w[`IOF_C_RUN];
          next_s.fmt = iof_fmt_e'(w[`IOF_C_FMT +: 3]);
          next_s.rx = w[`IOF_C_RX];
          next_s.ry = w[`IOF_C_RY];
          next_s.image_processing_core = w[`IOF_C_ISP];
          next_s.comp = w[`IOF_C_COMP];
          next_s.adapt = w[`IOF_C_ADAPT];
          next_s.hold = w[`IOF_C_HOLD];
          next_s.psel = w[`IOF_C_PSEL];
          // Depth changes mid-acquisition would corrupt alignment
          if (!s.run) begin
            next_s.adc = w[`IOF_C_ADC +: 2];
          end
        end
        `IOF_PAT: begin
          // Only the generator picked by the selector is changed
          if (s.psel) begin
            if (wb_sel_i[1]) begin
              next_s.pat_p = iof_pp_e'(wb_dat_i[`IOF_P_PIPE +: 2]);
            end
          end else if (wb_sel_i[0]) begin
            next_s.pat_s = wb_dat_i[`IOF_P_SENS];
          end
        end
        `IOF_ROIX: begin
          w = ({s.xw, s.xo} & ~m) | (wb_dat_i & m);
          next_s.xo = w[15:0];
          next_s.xw = w[31:16];
        end
        `IOF_ROIY: begin
          w = ({s.yh, s.yo} & ~m) | (wb_dat_i & m);
          next_s.yo = w[15:0];
          next_s.yh = w[31:16];
        end
        `IOF_MAXR: next_s.maxr = (s.maxr & ~m) | (wb_dat_i & m);
        default: begin
        end
      endcase
    end

    // Output slot drains on handshake
    if (s.ov && out_ready) begin
      next_s.ov = 1'b0;
    end

    // Pixel return: format and place into the output slot
    if (s.pend) begin
      next_s.pend = 1'b0;
      a16 = (s.adc == `IOF_ADC10) ? {pix_sample[9:0], 6'h00} :
        (s.adc == `IOF_ADC12) ? {pix_sample[11:0], 4'h0} :
        {pix_sample[13:0], 2'h0};
      lu = pix_luma;
      cb = pix_cb;
      cr = pix_cr;
      // Pattern replaces the sensor stream after gain and exposure
      if (s.m_pon) begin
        a16 = {s.m_pat, 8'h00};
        lu = s.m_pat;
        cb = `IOF_CHROMA_MID;
        cr = `IOF_CHROMA_MID;
      end
      b8 = a16[15:8];
      next_s.ocv = 1'b0;
      unique case (s.c_fmt)
        F_GREY8, F_RG8: next_s.od = {8'h00, b8};
        F_HALF, F_HALF_PK: begin
          next_s.od = {s.m_ph[0] ? cr : cb, lu};
          next_s.ocv = 1'b1;
        end
        F_QUARTER, F_QUARTER_PK: begin
          next_s.od = {s.m_ph == 2'h0 ? cb : s.m_ph == 2'h2 ? cr : 8'h00, lu};
          next_s.ocv = !s.m_ph[0];
        end
        default: next_s.od = a16;
      endcase
      // Downstream gamma and balance see the pattern as ordinary pixels
      next_s.ov = 1'b1;
      next_s.osof = s.m_sof;
      next_s.oeol = s.m_eol;
      next_s.oeof = s.m_eof;
      // Coding-cost estimate from neighbour residual
      res = 8'(b8 - s.prev);
      mag = res[7] ? 8'(-res) : res;
      if ({1'b0, mag} < (9'h002 << s.k)) begin
        bits = 4'h2;
      end else if ({1'b0, mag} < (9'h008 << s.k)) begin
        bits = 4'h4;
      end else if ({1'b0, mag} < (9'h020 << s.k)) begin
        bits = 4'h6;
      end else begin
        bits = 4'ha;
      end
      next_s.prev = b8;
      if (!s.c_adapt) begin
        next_s.k = 2'h0;
      end else if (bits == 4'ha && s.k != 2'h3) begin
        next_s.k = 2'(s.k + 2'h1);
      end else if (bits == 4'h2 && s.k != 2'h0) begin
        next_s.k = 2'(s.k - 2'h1);
      end
      next_s.cbits = s.cbits + 32'(bits);
      next_s.raw = s.raw + 32'(next_s.ocv ? 2 : (s.c_fmt == F_WIDE ? 2 : 1));
      next_s.wbits = s.wbits + (s.c_comp ? 32'(bits) :
        32'(next_s.ocv || s.c_fmt == F_WIDE ? 16 : 8));
    end

    // Datarate window of one second
    if (s.wcnt >= WIN_CYC - 32'h1) begin
      next_s.wcnt = '0;
      next_s.rate = {3'h0, next_s.wbits[31:3]};
      next_s.wbits = '0;
    end else begin
      next_s.wcnt = s.wcnt + 32'h1;
    end

    unique case (s.st)
      S_IDLE: begin
        if (s.run) begin
          next_s.st = S_SOF;
        end
      end
      S_SOF: begin
        if (!s.run) begin
          next_s.st = S_IDLE;
        end else if ({3'h0, s.wbits[31:3]} < s.maxr || s.hold) begin
          // Settings land only on a frame boundary
          next_s.c_fmt = s.fmt;
          next_s.c_rx = s.rx;
          next_s.c_ry = s.ry;
          next_s.c_comp = comp_ok;
          next_s.c_adapt = s.adapt;
          next_s.c_hold = s.hold;
          next_s.c_pat = s.pat_p;
          next_s.c_xo = s.xo;
          next_s.c_xw = s.xw;
          next_s.c_yo = s.yo;
          next_s.c_yh = s.yh;
          next_s.x = s.xo;
          next_s.y = s.yo;
          next_s.ph = '0;
          next_s.inc = '0;
          next_s.cbits = '0;
          next_s.raw = '0;
          next_s.drop = {3'h0, s.wbits[31:3]} >= s.maxr;
          if ({3'h0, s.wbits[31:3]} >= s.maxr) begin
            next_s.drops = s.drops + 32'h1;
          end
          next_s.st = S_SCAN;
        end
        // Without hold, waiting for the window lowers the frame rate
      end
      S_SCAN: begin
        if (issue) begin
          next_s.pend = 1'b1;
          next_s.m_sof = (s.x == s.c_xo) && (s.y == s.c_yo);
          next_s.m_eol = s.x == xl;
          next_s.m_eof = (s.x == xl) && (s.y == yl);
          next_s.m_ph = s.ph;
          next_s.ph = 2'(s.ph + 2'h1);
          next_s.m_pon = s.c_pat != PP_OFF;
          next_s.m_pat = (s.c_pat == PP_VAR) ?
            8'(s.x[7:0] + s.y[7:0] + s.fidx) : s.inc;
          next_s.inc = 8'(s.inc + 8'h01);
        end
        if (issue || s.drop) begin
          if (s.x == xl) begin
            next_s.x = s.c_xo;
            next_s.ph = '0;
            next_s.y = 16'(s.y + 16'h0001);
            if (s.y == yl) begin
              next_s.fidx = 8'(s.fidx + 8'h01);
              next_s.dcnt = `IOF_DIV_STEPS;
              next_s.drem = '0;
              next_s.dnum = {next_s.cbits[26:3], 8'h00};
              next_s.st = s.drop ? S_SOF : S_DIV;
            end
          end else begin
            next_s.x = 16'(s.x + 16'h0001);
          end
        end
      end
      S_DIV: begin
        // Restoring divide gives the ratio in 8.8 fixed point
        if (s.pend) begin
          next_s.dnum = s.dnum;
        end else if (!s.c_comp) begin
          next_s.ratio = `IOF_RATIO_ONE;
          next_s.st = S_SOF;
        end else if (s.dcnt == 6'h00) begin
          next_s.ratio = s.dnum[15:0];
          next_s.st = S_SOF;
        end else begin
          rem = {s.drem[30:0], s.dnum[31]};
          next_s.dnum = {s.dnum[30:0], rem >= s.raw};
          next_s.drem = (rem >= s.raw) ? rem - s.raw : rem;
          next_s.dcnt = 6'(s.dcnt - 6'h01);
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= RST;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Mirror is applied to the fetch address, so the ROI cuts the flipped frame
  assign fetch_req = issue;
  assign fetch_x = s.c_rx ? 16'(SENS_W - 1) - s.x : s.x;
  assign fetch_y = s.c_ry ? 16'(SENS_H - 1) - s.y : s.y;
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign out_valid = s.ov;
  assign out_data = s.od;
  assign out_cvalid = s.ocv;
  assign out_sof = s.osof;
  assign out_eol = s.oeol;
  assign out_eof = s.oeof;
  assign sensor_pattern_en = s.pat_s;
  assign adc_depth_sel = s.adc;
  assign acq_running = s.run;

endmodule
`default_nettype wire

// File: test/iof_assertions.sv
// Port-level assertions of the image output formatter
`timescale 1ns/1ps
`default_nettype none
module iof_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic fetch_req,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [15:0] out_data,
  input wire logic out_eol,
  input wire logic out_eof,
  input wire logic [1:0] adc_depth_sel,
  input wire logic acq_running
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence s_fetch;
    fetch_req && clk_en ##1 clk_en;
  endsequence
  sequence s_stall;
    out_valid && !out_ready && clk_en;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack long");
  a_fetch_answer: assert property (s_fetch |=> out_valid) else $error("beat late");
  a_fetch_gap: assert property (fetch_req |=> !fetch_req) else $error("fetch burst");
  // Downstream may stall any beat, so data must not slip while held
  a_out_hold: assert property (s_stall |=> out_valid && $stable(out_data)) else $error("beat lost");
  a_stall_fetch: assert property (s_stall |-> !fetch_req) else $error("fetch in stall");
  a_eof_eol: assert property (out_valid && out_eof |-> out_eol) else $error("eof not eol");
  a_adc_locked: assert property (acq_running && $past(acq_running) |-> $stable(adc_depth_sel))
    else $error("depth moved");
endmodule
bind iof_formatter iof_checker iof_checker_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .fetch_req(fetch_req), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_eol(out_eol), .out_eof(out_eof), .adc_depth_sel(adc_depth_sel),
  .acq_running(acq_running));
`default_nettype wire

// File: test/iof_sensor_model.sv
// Sensor-side model answering each pixel fetch one cycle later
`timescale 1ns/1ps
`default_nettype none
module iof_sensor_model (
  input wire logic core_clk,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_x,
  input wire logic [15:0] fetch_y,
  output logic [13:0] pix_sample = 14'h0,
  output logic [7:0] pix_luma = 8'h0,
  output logic [7:0] pix_cb = 8'h0,
  output logic [7:0] pix_cr = 8'h0
);
  // Lines invert outside a fetch, so a late sample cannot pass by luck
  always @(posedge core_clk) begin
    if (fetch_req) begin
      pix_sample <= {2'h0, fetch_x[3:0] + 4'h1, fetch_y[3:0] ^ 4'hc, 4'h5};
      pix_luma <= 8'h10 + fetch_x[7:0];
      pix_cb <= 8'h40 + fetch_x[7:0];
      pix_cr <= 8'h60 + fetch_x[7:0];
    end else begin
      pix_sample <= ~pix_sample;
      pix_luma <= ~pix_luma;
      pix_cb <= ~pix_cb;
      pix_cr <= ~pix_cr;
    end
  end
endmodule
`default_nettype wire

// File: test/iof_formatter_tb_top.sv
// Self-checking bench of the image output formatter
`timescale 1ns/1ps
`default_nettype none
`include "iof_map.svh"
module iof_formatter_tb_top;
  typedef struct {logic [11:0] c; logic [9:0] p; logic s; logic [16:0] m, b0, b1;} iof_row_s;
  logic core_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, cap = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, out_ready = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, fetch_req, out_valid, out_cvalid, out_sof, out_eol, out_eof;
  logic sensor_pattern_en, acq_running;
  logic [15:0] fetch_x, fetch_y, out_data;
  logic [13:0] pix_sample;
  logic [7:0] pix_luma, pix_cb, pix_cr;
  logic [1:0] adc_depth_sel;
  logic [16:0] beat [16];
  logic [31:0] cw [4] = '{32'h080, 32'h082, 32'h0c0, 32'h084};
  int n = 0, bad_count = 0, checks_done = 0, ticks = 0;
  // Row: control, pattern, sensor pattern level, beat1 mask, beat0, beat1
  iof_row_s rows [13] = '{
    '{12'h001, 10'h000, 1'h0, 17'h1ffff, 17'h0001c, 17'h0002c},
    '{12'h005, 10'h000, 1'h0, 17'h1ffff, 17'h01c50, 17'h02c50},
    '{12'h007, 10'h000, 1'h0, 17'h100ff, 17'h14010, 17'h10011},
    '{12'h009, 10'h000, 1'h0, 17'h1ffff, 17'h14010, 17'h00011},
    '{12'h011, 10'h000, 1'h0, 17'h1ffff, 17'h0008c, 17'h0007c},
    '{12'h021, 10'h000, 1'h0, 17'h1ffff, 17'h0001f, 17'h0002f},
    '{12'h401, 10'h100, 1'h0, 17'h1ffff, 17'h00000, 17'h00001},
    '{12'h401, 10'h200, 1'h0, 17'h1ffff, 17'h00000, 17'h00001},
    '{12'h401, 10'h000, 1'h0, 17'h1ffff, 17'h0001c, 17'h0002c},
    '{12'h001, 10'h001, 1'h1, 17'h1ffff, 17'h0001c, 17'h0002c},
    '{12'h401, 10'h100, 1'h1, 17'h1ffff, 17'h00000, 17'h00001},
    '{12'h401, 10'h000, 1'h1, 17'h1ffff, 17'h0001c, 17'h0002c},
    '{12'h001, 10'h000, 1'h0, 17'h1ffff, 17'h0001c, 17'h0002c}};
  iof_formatter #(.SENS_W(8), .SENS_H(4), .WIN_CYC(32'h64)) iof_formatter_inst (.core_clk,
    .sys_rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .fetch_req, .fetch_x, .fetch_y, .pix_sample, .pix_luma, .pix_cb,
    .pix_cr, .out_valid, .out_ready, .out_data, .out_cvalid, .out_sof, .out_eol, .out_eof,
    .sensor_pattern_en, .adc_depth_sel, .acq_running);
  iof_sensor_model iof_sensor_model_inst (.core_clk, .fetch_req, .fetch_x, .fetch_y,
    .pix_sample, .pix_luma, .pix_cb, .pix_cr);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Downstream stalls one cycle in four so held beats get exercised
  always @(posedge core_clk) begin
    ticks <= ticks + 1;
    out_ready <= ticks[1:0] != 2'h3;
    if (cap && out_valid && out_ready) begin
      beat[n] <= {out_cvalid, out_data};
      n <= n + 1;
      if (out_eof) cap <= 1'h0;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'h1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic idle();
    rd = 32'h8;
    while (rd[3] !== 1'h0) wb(1'h0, `IOF_STAT, 32'h0);
  endtask
  // Config is written stopped, then one frame is captured; rows expect 12-bit depth
  task automatic frame(input logic [31:0] ctl, input logic [31:0] pat);
    wb(1'h1, `IOF_CTRL, (ctl | 32'h800) & ~32'h1);
    wb(1'h1, `IOF_PAT, pat);
    @(posedge core_clk);
    n <= 0;
    cap <= 1'h1;
    wb(1'h1, `IOF_CTRL, ctl | 32'h800);
    while (cap) @(posedge core_clk);
    wb(1'h1, `IOF_CTRL, (ctl | 32'h800) & ~32'h1);
    idle();
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    $display("mismatch timeout expected done seen hang");
    conclude();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    check("rst_out", {wb_ack_o, fetch_req, out_valid, acq_running, sensor_pattern_en,
      adc_depth_sel}, 32'h1);
    wb(1'h0, `IOF_MAXR, 32'h0);
    check("maxr_rst", rd, 32'hffffffff);
    wb(1'h1, 8'h40, 32'h5a5a5a5a);
    wb(1'h0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'h1, `IOF_ROIX, 32'h00040000);
    wb(1'h1, `IOF_ROIY, 32'h00020000);
    $display("reset test done");
    foreach (rows[i]) begin
      frame(rows[i].c, rows[i].p);
      check("beats", n, 32'h8);
      if (rows[i].m != 17'h0) check("beat0", beat[0], rows[i].b0);
      check("beat1", beat[1] & rows[i].m, rows[i].b1 & rows[i].m);
      check("sensor_pattern_en", sensor_pattern_en, rows[i].s);
      $display("row %0d done", i);
    end
    foreach (cw[i]) begin
      wb(1'h1, `IOF_CTRL, cw[i]);
      wb(1'h0, `IOF_STAT, 32'h0);
      check("comp_allowed", rd[0], i < 2);
    end
    wb(1'h0, `IOF_RATIO, 32'h0);
    check("ratio_raw", rd, 32'h100);
    $display("compression test done");
    wb(1'h1, `IOF_CTRL, 32'h801);
    wb(1'h1, `IOF_CTRL, 32'h1001);
    check("adc_running", adc_depth_sel, 2'h1);
    wb(1'h1, `IOF_CTRL, 32'h0);
    idle();
    wb(1'h1, `IOF_CTRL, 32'h1000);
    @(posedge core_clk);
    check("adc_stopped", adc_depth_sel, 2'h2);
    $display("depth test done");
    wb(1'h1, `IOF_MAXR, 32'h1);
    wb(1'h1, `IOF_CTRL, 32'h201);
    repeat (600) @(posedge core_clk);
    wb(1'h1, `IOF_CTRL, 32'h200);
    idle();
    wb(1'h0, `IOF_DROPS, 32'h0);
    check("drops_seen", rd != 32'h0, 1'h1);
    wb(1'h1, `IOF_MAXR, 32'hffffffff);
    wb(1'h1, `IOF_CTRL, 32'h201);
    wb(1'h0, `IOF_DROPS, 32'h0);
    check("drops_clear", rd, 32'h0);
    $display("drop test done");
    conclude();
  end
endmodule
`default_nettype wire
